// >>> design/psc_loader.sv
// passive serial configuration loader, device side
// assumes a host drives request, serial clock and data; lines are open drain
//
// What this block does
// (R1) power-on delay picked by delay-select pin
// (R2) during power-on: reset, status low, pins floating
// (R3) pins stay floating until configuration ends
// (R4) weak pull-ups follow the pull-enable pin
// (R5) stages run reset, configuration, initialization
// (R6) stay in reset while request or status low
// (R7) host starts by raising the request line
// (R8) request high releases the status line
// (R9) status released then configuration data accepted
// (R10) host sends one bit per serial clock
// (R11) host clocks bits until completion line rises
// (R12) host restarts itself after any error
// (R13) initialization needs no user startup clock
// (R14) chain enable out feeds next device in
// (R15) shared completion line starts all devices together
// (R16) shared status line low halts configuration
// (R17) host gives two falling clock edges after done
// (R18) bits sampled on serial clock rising edge
// (R19) last bit releases done, lowers chain enable
// (R20) error pulls status low, back to reset
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module psc_loader
#(
   parameter int unsigned POR_LONG_CYC  = psc_pkg::POR_LONG_CYC,
   parameter int unsigned POR_SHORT_CYC = psc_pkg::POR_SHORT_CYC
)
(
   input  wire logic                        REF_CLK_I,
   input  wire logic                        NRST_I,
   input  wire logic                        CE_I,
   input  wire logic                        CFG_REQ_N_I,
   input  wire logic                        STATUS_I,
   output logic                             STATUS_O,
   output logic                             STATUS_OE_O,
   input  wire logic                        DONE_I,
   output logic                             DONE_O,
   output logic                             DONE_OE_O,
   input  wire logic                        CHAIN_EN_N_I,
   output logic                             CHAIN_EN_N_O,
   input  wire logic                        SERIAL_CONFIG_CLOCK_I,
   input  wire logic                        SERIAL_CONFIG_DATA_I,
   input  wire logic                        RESET_DELAY_SELECT_I,
   input  wire logic                        IO_WEAK_PULL_ENABLE_N_I,
   output logic                             IO_HIZ_O,
   output logic                             IO_PULLUP_EN_O,
   output logic                             USER_MODE_O,
   input  wire logic [psc_pkg::ADDR_W-1:0]  REG_ADDR_I,
   input  wire logic [psc_pkg::DATA_W-1:0]  REG_WDATA_I,
   input  wire logic                        REG_WR_I,
   input  wire logic                        REG_RD_I,
   output logic [psc_pkg::DATA_W-1:0]       REG_RDATA_O
);

   // =========================================================
   // pin synchronisation
   psc_pin_if pins ();

   assign pins.raw = {IO_WEAK_PULL_ENABLE_N_I, RESET_DELAY_SELECT_I, SERIAL_CONFIG_DATA_I,
                      SERIAL_CONFIG_CLOCK_I, CHAIN_EN_N_I, DONE_I, STATUS_I, CFG_REQ_N_I};

   psc_sync u_sync
   (
      .REF_CLK_I (REF_CLK_I),
      .NRST_I    (NRST_I),
      .CE_I      (CE_I),
      .pins      (pins.sync_mp)
   );

   logic cfg_req_s;
   logic status_s;
   logic done_s;
   logic chain_in_n_s;
   logic sclk_s;
   logic sdata_s;
   logic sel_s;
   logic pull_n_s;
   logic sclk_d;
   logic sclk_rise;
   logic sclk_fall;

   assign cfg_req_s    = pins.sync[psc_pkg::PIN_CFG_REQ_N];
   assign status_s     = pins.sync[psc_pkg::PIN_STATUS];
   assign done_s       = pins.sync[psc_pkg::PIN_DONE];
   assign chain_in_n_s = pins.sync[psc_pkg::PIN_CHAIN_N];
   assign sclk_s       = pins.sync[psc_pkg::PIN_SCLK];
   assign sdata_s      = pins.sync[psc_pkg::PIN_SDATA];
   assign sel_s        = pins.sync[psc_pkg::PIN_DLY_SEL];
   assign pull_n_s     = pins.sync[psc_pkg::PIN_PULL_N];

   always_ff @(posedge REF_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         sclk_d <= 1'b0;
      else if (CE_I)
         sclk_d <= sclk_s;
   end

   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;

   // =========================================================
   // registers written by software
   logic [31:0] cfg_len;
   logic [1:0]  check;

   always_ff @(posedge REF_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         cfg_len <= psc_pkg::LEN_RST;
         check   <= psc_pkg::CHECK_RST;
      end
      else if (CE_I && REG_WR_I)
      begin
         if (REG_ADDR_I == psc_pkg::REG_LEN)
            cfg_len <= REG_WDATA_I;
         if (REG_ADDR_I == psc_pkg::REG_CHECK)
            check <= REG_WDATA_I[1:0];
      end
   end

   // =========================================================
   // power-on delay
   psc_pkg::psc_stage_t   stage;
   psc_pkg::psc_stage_t   next_stage;
   psc_pkg::psc_por_cnt_t por_cnt;
   logic [1:0]            por_arm_cnt;
   logic                  por_armed;

   always_ff @(posedge REF_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         por_cnt     <= '0;
         por_arm_cnt <= 2'h0;
         por_armed   <= 1'b0;
      end
      else if (CE_I && stage == psc_pkg::ST_POR)
      begin
         if (!por_armed && por_arm_cnt != psc_pkg::POR_ARM_CYC)
            por_arm_cnt <= por_arm_cnt + 2'h1;
         else if (!por_armed)
         begin
            por_armed <= 1'b1;
            por_cnt   <= sel_s ? psc_pkg::psc_por_cnt_t'(POR_SHORT_CYC) :
                                 psc_pkg::psc_por_cnt_t'(POR_LONG_CYC);   // [R1]
         end
         else if (por_cnt != '0)
            por_cnt <= por_cnt - psc_pkg::psc_por_cnt_t'(1);
      end
   end

   // =========================================================
   // serial intake
   logic        bit_take;
   logic        last_bit;
   logic        bad_check;
   logic        good_last;
   logic        err_evt;
   logic        live;
   logic [31:0] bit_cnt;
   logic [31:0] rx_shift;
   logic        parity;
   logic [1:0]  fall_cnt;
   logic        err_hold;
   logic        done_rel;

   assign live      = cfg_req_s && status_s;
   assign bit_take  = stage == psc_pkg::ST_CONFIG && live && sclk_rise && !chain_in_n_s; // [R14]
   assign last_bit  = bit_cnt + 32'h0000_0001 == cfg_len;
   assign bad_check = check[psc_pkg::CHECK_EN] &&
                      ((parity ^ sdata_s) != check[psc_pkg::CHECK_PAR]);
   assign err_evt   = bit_take && last_bit && bad_check;
   assign good_last = bit_take && last_bit && !bad_check;

   always_ff @(posedge REF_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         bit_cnt  <= 32'h0000_0000;
         rx_shift <= 32'h0000_0000;
         parity   <= 1'b0;
      end
      else if (CE_I)
      begin
         if (stage != psc_pkg::ST_CONFIG)
         begin
            bit_cnt <= 32'h0000_0000;
            parity  <= 1'b0;
         end
         else if (bit_take)
         begin
            bit_cnt  <= bit_cnt + 32'h0000_0001;                 // [R18]
            rx_shift <= {rx_shift[30:0], sdata_s};
            parity   <= parity ^ sdata_s;
         end
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         fall_cnt <= 2'h0;
      else if (CE_I)
      begin
         if (stage != psc_pkg::ST_INIT)
            fall_cnt <= 2'h0;
         else if (done_s && sclk_fall)
            fall_cnt <= fall_cnt + 2'h1;                          // [R17]
      end
   end

   // error holds status low until the host drops the request
   always_ff @(posedge REF_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         err_hold <= 1'b0;
      else if (CE_I)
      begin
         if (err_evt)
            err_hold <= 1'b1;                                     // [R20]
         else if (!cfg_req_s)
            err_hold <= 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         done_rel <= 1'b0;
      else if (CE_I)
      begin
         if (good_last)
            done_rel <= 1'b1;                                     // [R19]
         else if (next_stage == psc_pkg::ST_RESET)
            done_rel <= 1'b0;
      end
   end

   // =========================================================
   // stage sequencing
   always_comb
   begin
      next_stage = stage;
      case (stage)
         psc_pkg::ST_POR:
            if (por_armed && por_cnt == '0)
               next_stage = psc_pkg::ST_RESET;
         psc_pkg::ST_RESET:
            if (live && !err_hold)
               next_stage = psc_pkg::ST_CONFIG;                   // [R6] [R9]
         psc_pkg::ST_CONFIG:
            if (!live || err_evt)
               next_stage = psc_pkg::ST_RESET;                    // [R16] [R20]
            else if (good_last)
               next_stage = psc_pkg::ST_INIT;                     // [R5]
         psc_pkg::ST_INIT:
            if (!live)
               next_stage = psc_pkg::ST_RESET;
            else if (done_s && sclk_fall && fall_cnt == psc_pkg::INIT_FALL_EDGES - 2'h1)
               next_stage = psc_pkg::ST_USER;                     // [R15]
         psc_pkg::ST_USER:
            if (!cfg_req_s)
               next_stage = psc_pkg::ST_RESET;
         default:
            next_stage = psc_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge REF_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         stage <= psc_pkg::ST_POR;
      else if (CE_I)
         stage <= next_stage;
   end

   // =========================================================
   // pin drive
   assign STATUS_O       = 1'b0;
   assign STATUS_OE_O    = stage == psc_pkg::ST_POR || err_hold || !cfg_req_s; // [R2] [R8]
   assign DONE_O         = 1'b0;
   assign DONE_OE_O      = !done_rel;
   assign CHAIN_EN_N_O   = !done_rel;                             // [R14]
   assign IO_HIZ_O       = stage != psc_pkg::ST_USER;             // [R2] [R3]
   assign IO_PULLUP_EN_O = stage != psc_pkg::ST_USER && stage != psc_pkg::ST_POR &&
                           !pull_n_s;                             // [R4]
   assign USER_MODE_O    = stage == psc_pkg::ST_USER;

   // =========================================================
   // register reads
   always_ff @(posedge REF_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         REG_RDATA_O <= 32'h0000_0000;
      else if (CE_I)
      begin
         REG_RDATA_O <= 32'h0000_0000;
         if (REG_RD_I)
         begin
            case (REG_ADDR_I)
               psc_pkg::REG_LEN:    REG_RDATA_O <= cfg_len;
               psc_pkg::REG_CHECK:  REG_RDATA_O <= {30'h0000_0000, check};
               psc_pkg::REG_STATUS: REG_RDATA_O <= {26'h000_0000, por_armed, done_rel,
                                                    err_hold, stage};
               psc_pkg::REG_BITCNT: REG_RDATA_O <= bit_cnt;
               psc_pkg::REG_SHIFT:  REG_RDATA_O <= rx_shift;
               default:             REG_RDATA_O <= 32'h0000_0000;
            endcase
         end
      end
   end

   // =========================================================
   // checks
   default clocking chk_cb @(posedge REF_CLK_I iff CE_I);
   endclocking
   default disable iff (!NRST_I);

   chk_por_length: assert property ( // [R1]
      $rose(por_armed) |-> por_cnt == ($past(sel_s) ? psc_pkg::psc_por_cnt_t'(POR_SHORT_CYC)
                                                   : psc_pkg::psc_por_cnt_t'(POR_LONG_CYC)))
      else $error("power-on count loaded with wrong length");
   chk_por_drive: assert property ( // [R2]
      stage == psc_pkg::ST_POR |-> STATUS_OE_O && IO_HIZ_O && !IO_PULLUP_EN_O)
      else $error("power-on drive wrong");
   chk_pins_float: assert property ( // [R3]
      !done_rel |-> IO_HIZ_O && !USER_MODE_O)
      else $error("pins driven before configuration end");
   chk_pullup_follow: assert property ( // [R4]
      stage == psc_pkg::ST_CONFIG |-> IO_PULLUP_EN_O == !pull_n_s)
      else $error("pull-up enable wrong");
   chk_stage_order: assert property ( // [R5]
      stage == psc_pkg::ST_CONFIG && $past(stage) != psc_pkg::ST_CONFIG
      |-> $past(stage) == psc_pkg::ST_RESET)
      else $error("configuration entered out of order");
   chk_reset_hold: assert property ( // [R6]
      stage == psc_pkg::ST_RESET && !live |=> stage == psc_pkg::ST_RESET)
      else $error("left reset while request or status low");
   chk_status_release: assert property ( // [R8]
      cfg_req_s && !err_hold && stage != psc_pkg::ST_POR |-> !STATUS_OE_O)
      else $error("status not released");
   chk_config_entry: assert property ( // [R9]
      stage == psc_pkg::ST_RESET && live && !err_hold |=> stage == psc_pkg::ST_CONFIG)
      else $error("configuration not entered");
   chk_bit_sample: assert property ( // [R18]
      bit_take |=> bit_cnt == $past(bit_cnt) + 32'h0000_0001 && rx_shift[0] == $past(sdata_s))
      else $error("bit not taken on rising edge");
   chk_handoff: assert property ( // [R19]
      good_last |=> !DONE_OE_O && !CHAIN_EN_N_O && stage == psc_pkg::ST_INIT)
      else $error("hand-off after last bit wrong");
   chk_error_reset: assert property ( // [R20]
      err_evt |=> stage == psc_pkg::ST_RESET && STATUS_OE_O ##1 stage == psc_pkg::ST_RESET)
      else $error("error did not return to reset");
   chk_chain_halt: assert property ( // [R16]
      stage == psc_pkg::ST_CONFIG && !status_s |=> stage == psc_pkg::ST_RESET)
      else $error("configuration not halted on status low");
   chk_init_wait: assert property ( // [R15]
      stage == psc_pkg::ST_INIT && !done_s |=> stage != psc_pkg::ST_USER)
      else $error("user mode before completion line high");

   cov_user_mode:  cover property (stage == psc_pkg::ST_INIT ##1 stage == psc_pkg::ST_USER);
   cov_error:      cover property (err_evt);
   cov_chain_wait: cover property (stage == psc_pkg::ST_CONFIG && sclk_rise && chain_in_n_s);
   cov_halt:       cover property (stage == psc_pkg::ST_CONFIG && !status_s);

endmodule

// >>> inc/psc_pkg.sv
// package for the passive serial configuration loader
// assumes a 200 MHz reference clock and pins that arrive asynchronously
package psc_pkg;

   // =========================================================
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS   = 5;
   localparam int unsigned NS_PER_MS       = 1000000;
   localparam int unsigned POR_LONG_MS     = 100;
   localparam int unsigned POR_SHORT_MS    = 12;
   localparam int unsigned POR_LONG_CYC    = POR_LONG_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned POR_SHORT_CYC   = POR_SHORT_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int unsigned POR_CNT_W       = 25;
   localparam logic [1:0]  POR_ARM_CYC     = 2'h3;
   localparam logic [1:0]  INIT_FALL_EDGES = 2'h2;

   typedef logic [POR_CNT_W-1:0] psc_por_cnt_t;

   // =========================================================
   // register port
   localparam int unsigned ADDR_W       = 5;
   localparam int unsigned DATA_W       = 32;
   localparam logic [4:0]  REG_LEN      = 5'h00;
   localparam logic [4:0]  REG_CHECK    = 5'h04;
   localparam logic [4:0]  REG_STATUS   = 5'h08;
   localparam logic [4:0]  REG_BITCNT   = 5'h0C;
   localparam logic [4:0]  REG_SHIFT    = 5'h10;
   localparam logic [31:0] LEN_RST      = 32'h0000_0100;
   localparam logic [1:0]  CHECK_RST    = 2'h0;
   localparam int unsigned CHECK_PAR    = 0;
   localparam int unsigned CHECK_EN     = 1;
   localparam int unsigned ST_STAGE_LSB = 0;
   localparam int unsigned ST_ERR       = 3;
   localparam int unsigned ST_DONE      = 4;
   localparam int unsigned ST_ARMED     = 5;

   // =========================================================
   // synchronised pin vector
   localparam int unsigned PIN_W         = 8;
   localparam int unsigned PIN_CFG_REQ_N = 0;
   localparam int unsigned PIN_STATUS    = 1;
   localparam int unsigned PIN_DONE      = 2;
   localparam int unsigned PIN_CHAIN_N   = 3;
   localparam int unsigned PIN_SCLK      = 4;
   localparam int unsigned PIN_SDATA     = 5;
   localparam int unsigned PIN_DLY_SEL   = 6;
   localparam int unsigned PIN_PULL_N    = 7;
   localparam logic [7:0]  PIN_RST       = 8'h00;

   // =========================================================
   // configuration stages
   typedef enum logic [2:0]
   {
      ST_POR    = 3'b000,
      ST_RESET  = 3'b001,
      ST_CONFIG = 3'b010,
      ST_INIT   = 3'b011,
      ST_USER   = 3'b100
   } psc_stage_t;

endpackage

// >>> inc/psc_pin_if.sv
// interface carrying raw pins to the synchroniser and synced levels back
// assumes one reference clock domain on the synced side
`timescale 1ns/10ps
interface psc_pin_if;
   logic [psc_pkg::PIN_W-1:0] raw;
   logic [psc_pkg::PIN_W-1:0] sync;
   modport core_mp (output raw, input sync);
   modport sync_mp (input raw, output sync);
endinterface

// >>> design/psc_sync.sv
// two flip-flop synchroniser for all asynchronous pins of the loader
// assumes the clock enable freezes it along with the rest of the block
`timescale 1ns/10ps
module psc_sync
(
   input  wire logic     REF_CLK_I,
   input  wire logic     NRST_I,
   input  wire logic     CE_I,
   psc_pin_if.sync_mp    pins
);

   // =========================================================
   // first stage feeds only the second
   logic [psc_pkg::PIN_W-1:0] meta;
   logic [psc_pkg::PIN_W-1:0] hold;

   always_ff @(posedge REF_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         meta <= psc_pkg::PIN_RST;
         hold <= psc_pkg::PIN_RST;
      end
      else if (CE_I)
      begin
         meta <= pins.raw;
         hold <= meta;
      end
   end

   assign pins.sync = hold;

endmodule

// >>> testbench/psc_host_model.sv
// host programmer model: request line, serial clock and serial data
// assumes the completion line comes back as its resolved wired level
`timescale 1ns/10ps
module psc_host_model
(
   input  wire logic done_line_i,
   output logic      cfg_req_n_o,
   output logic      sclk_o,
   output logic      sdata_o
);
   // =========================================================
   // line levels; half_ns may be raised for a slow host
   real half_ns;
   initial
   begin
      half_ns     = 62.5;
      cfg_req_n_o = 1'b0;
      sclk_o      = 1'b0; // no user startup clock is ever driven
      sdata_o     = 1'b1;
   end

   // =========================================================
   // request line
   task automatic drop();
      #1;
      cfg_req_n_o = 1'b0;
   endtask
   task automatic raise();
      #1;
      cfg_req_n_o = 1'b1; // low to high starts a cycle
   endtask
   task automatic request();
      drop();
      #500;
      raise(); // fresh cycle after an error
   endtask

   // =========================================================
   // serial stream, msb first, data moves on the falling edge
   task automatic send(input logic [31:0] bits, input int n);
      int i;
      i = 0;
      #1.3;
      while (i < n && done_line_i !== 1'b1) // stop once done is seen
      begin
         sdata_o = bits[n-1-i]; // one bit per clock
         #(half_ns);
         sclk_o = 1'b1;
         #(half_ns);
         sclk_o = 1'b0;
         i++;
      end
      sdata_o = 1'b1; // released line sits at its pull-up
   endtask
   task automatic fin();
      repeat (2) // two falling edges after done
      begin
         #(half_ns);
         sclk_o = 1'b1;
         #(half_ns);
         sclk_o = 1'b0;
      end
   endtask
endmodule

// >>> testbench/tb_psc_loader.sv
// testbench for the passive serial configuration loader
// assumes the host model file and shortened power-on counts
`timescale 1ns/10ps
module tb_psc_loader;
   localparam int unsigned LONG_CYC  = 40;
   localparam int unsigned SHORT_CYC = 12;
   localparam int unsigned NB        = 24;
   typedef struct {string name; logic [31:0] exp; logic [31:0] mask;} psc_note_t;
   logic        REF_CLK_I;
   logic        NRST_I;
   logic        CE_I;
   logic        CHAIN_EN_N_I;
   logic        RESET_DELAY_SELECT_I;
   logic        IO_WEAK_PULL_ENABLE_N_I;
   logic [4:0]  REG_ADDR_I;
   logic [31:0] REG_WDATA_I;
   logic        REG_WR_I;
   logic        REG_RD_I;
   logic [31:0] REG_RDATA_O;
   logic        STATUS_OE_O, DONE_OE_O, CHAIN_EN_N_O, IO_HIZ_O, IO_PULLUP_EN_O, USER_MODE_O;
   logic        cfg_req_n, sclk, sdata, status_line, done_line, ext_stat_low, ext_done_low;
   logic        rd_seen, par;
   logic [31:0] bits;
   int          error_cnt, n_checks, t_long, t_short, seed;
   psc_note_t   notes[$];
   psc_note_t   cur_note;

   // =========================================================
   // wired lines with pull-ups, clock, design and host
   assign status_line = ~(STATUS_OE_O | ext_stat_low);
   assign done_line   = ~(DONE_OE_O | ext_done_low);
   initial REF_CLK_I = 1'b0;
   always #2.5 REF_CLK_I = ~REF_CLK_I;
   psc_loader #(.POR_LONG_CYC(LONG_CYC), .POR_SHORT_CYC(SHORT_CYC)) dut
   (
      .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .CE_I(CE_I), .CFG_REQ_N_I(cfg_req_n),
      .STATUS_I(status_line), .STATUS_O(), .STATUS_OE_O(STATUS_OE_O),
      .DONE_I(done_line), .DONE_O(), .DONE_OE_O(DONE_OE_O),
      .CHAIN_EN_N_I(CHAIN_EN_N_I), .CHAIN_EN_N_O(CHAIN_EN_N_O),
      .SERIAL_CONFIG_CLOCK_I(sclk), .SERIAL_CONFIG_DATA_I(sdata),
      .RESET_DELAY_SELECT_I(RESET_DELAY_SELECT_I),
      .IO_WEAK_PULL_ENABLE_N_I(IO_WEAK_PULL_ENABLE_N_I), .IO_HIZ_O(IO_HIZ_O),
      .IO_PULLUP_EN_O(IO_PULLUP_EN_O), .USER_MODE_O(USER_MODE_O),
      .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
      .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O)
   );
   psc_host_model host
   (
      .done_line_i(done_line), .cfg_req_n_o(cfg_req_n), .sclk_o(sclk), .sdata_o(sdata)
   );

   // =========================================================
   // comparison, verdict and bounded waits
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic check1(input string name, input logic seen, input logic exp);
      check(name, {31'h0, seen}, {31'h0, exp});
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic fail_out(input string name);
      check(name, 32'h0000_0000, 32'h0000_0001);
      summarize();
   endtask
   task automatic wait_oe(input logic v);
      int k;
      k = 0;
      while (STATUS_OE_O !== v)
      begin
         @(posedge REF_CLK_I);
         k++;
         if (k > 200)
            fail_out("status_wait");
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge REF_CLK_I);
   endtask

   // =========================================================
   // register bus master; a read leaves a note for the monitor
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge REF_CLK_I);
      REG_ADDR_I  <= a;
      REG_WDATA_I <= d;
      REG_WR_I    <= 1'b1;
      @(posedge REF_CLK_I);
      REG_WR_I    <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m,
                     input string nm);
      psc_note_t n;
      n.name = nm;
      n.exp  = e;
      n.mask = m;
      @(posedge REF_CLK_I);
      REG_ADDR_I <= a;
      REG_RD_I   <= 1'b1;
      notes.push_back(n);
      @(posedge REF_CLK_I);
      REG_RD_I   <= 1'b0;
   endtask
   always @(posedge REF_CLK_I)
   begin
      rd_seen <= REG_RD_I;
      if (rd_seen === 1'b1 && notes.size() > 0)
      begin
         cur_note = notes.pop_front();
         check(cur_note.name, REG_RDATA_O & cur_note.mask, cur_note.exp);
      end
   end

   // =========================================================
   // power-on with a chosen delay; counts cycles until it ends
   task automatic do_reset(input logic sel, output int cyc);
      @(posedge REF_CLK_I);
      NRST_I               <= 1'b0;
      RESET_DELAY_SELECT_I <= sel;
      ticks(5);
      check1("hiz_por", IO_HIZ_O, 1'h1);
      check1("pull_por", IO_PULLUP_EN_O, 1'h0);
      NRST_I <= 1'b1;
      cyc = 0;
      while (IO_PULLUP_EN_O !== 1'b1)
      begin
         @(posedge REF_CLK_I);
         cyc++;
         if (cyc == 6)
            check1("stat_por", STATUS_OE_O, 1'h1);
         if (cyc > 500)
            fail_out("por_wait");
      end
   endtask

   // =========================================================
   // main sequence
   initial
   begin
      NRST_I = 1'b0;
      CE_I = 1'b1;
      CHAIN_EN_N_I = 1'b1;
      RESET_DELAY_SELECT_I = 1'b0;
      IO_WEAK_PULL_ENABLE_N_I = 1'b0;
      REG_ADDR_I = 5'h00;
      REG_WDATA_I = 32'h0000_0000;
      REG_WR_I = 1'b0;
      REG_RD_I = 1'b0;
      rd_seen = 1'b0;
      ext_stat_low = 1'b0;
      ext_done_low = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      seed = $urandom(8);
      bits = $urandom & 32'h00FF_FFFF;
      par = ^bits;
      do_reset(1'b0, t_long);
      do_reset(1'b1, t_short);
      check("por_delta", 32'(t_long - t_short), 32'(LONG_CYC - SHORT_CYC));
      IO_WEAK_PULL_ENABLE_N_I <= 1'b1;
      ticks(6);
      check1("pull_off", IO_PULLUP_EN_O, 1'h0);
      IO_WEAK_PULL_ENABLE_N_I <= 1'b0;
      rd(psc_pkg::REG_LEN, psc_pkg::LEN_RST, 32'hFFFF_FFFF, "len_rst");
      rd(psc_pkg::REG_CHECK, {30'h0, psc_pkg::CHECK_RST}, 32'h0000_0003, "check_rst");
      rd(psc_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0007, "stage_reset");
      rd(5'h14, 32'h0000_0000, 32'hFFFF_FFFF, "unmapped");
      wr(psc_pkg::REG_LEN, NB);
      wr(psc_pkg::REG_CHECK, {30'h0, 1'b1, par});
      check1("stat_held", STATUS_OE_O, 1'h1);
      host.raise();
      wait_oe(1'b0);
      ticks(10);
      rd(psc_pkg::REG_STATUS, 32'h0000_0002, 32'h0000_0007, "stage_cfg");
      host.send(bits, 4);
      rd(psc_pkg::REG_BITCNT, 32'h0000_0000, 32'hFFFF_FFFF, "chain_block");
      CHAIN_EN_N_I <= 1'b0;
      ticks(4);
      host.send(bits, NB);
      ticks(4);
      check1("done_rel", DONE_OE_O, 1'h0);
      check1("chain_out", CHAIN_EN_N_O, 1'h0);
      check1("hiz_cfg", IO_HIZ_O, 1'h1);
      rd(psc_pkg::REG_SHIFT, bits, 32'h00FF_FFFF, "shift");
      rd(psc_pkg::REG_BITCNT, 32'h0000_0000, 32'hFFFF_FFFF, "bitcnt_init");
      rd(psc_pkg::REG_STATUS, 32'h0000_0003, 32'h0000_0007, "stage_init");
      ext_done_low <= 1'b1;
      host.fin();
      ticks(6);
      check1("user_shared", USER_MODE_O, 1'h0);
      ext_done_low <= 1'b0;
      host.fin();
      ticks(6);
      check1("user_on", USER_MODE_O, 1'h1);
      check1("hiz_user", IO_HIZ_O, 1'h0);
      check1("pull_user", IO_PULLUP_EN_O, 1'h0);
      host.drop();
      ticks(6);
      check1("user_drop", USER_MODE_O, 1'h0);
      check1("stat_drop", STATUS_OE_O, 1'h1);
      wr(psc_pkg::REG_CHECK, {30'h0, 1'b1, ~par});
      host.raise();
      wait_oe(1'b0);
      ticks(10);
      host.send(bits, NB);
      ticks(4);
      check1("err_stat", STATUS_OE_O, 1'h1);
      check1("err_done", DONE_OE_O, 1'h1);
      rd(psc_pkg::REG_STATUS, 32'h0000_0009, 32'h0000_000F, "err_hold");
      host.request();
      wait_oe(1'b0);
      ticks(10);
      rd(psc_pkg::REG_STATUS, 32'h0000_0002, 32'h0000_000F, "restart");
      host.send(bits, 8);
      // clock enable low: serial edges in this gap must not be counted
      CE_I <= 1'b0;
      host.send(bits, 3);
      CE_I <= 1'b1;
      ticks(4);
      rd(psc_pkg::REG_BITCNT, 32'h0000_0008, 32'hFFFF_FFFF, "bitcnt");
      ext_stat_low <= 1'b1;
      ticks(6);
      rd(psc_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0007, "chain_halt");
      ext_stat_low <= 1'b0;
      ticks(4);
      check("notes_left", notes.size(), 32'h0000_0000);
      summarize();
   end
endmodule
